/* File: core/serial_link_pkg.sv */
package serial_link_pkg;

   // register byte offsets on the wishbone bus
   localparam logic [3:0] reg_baud_all   = 4'h0;
   localparam logic [3:0] reg_baud_port1 = 4'h4;
   localparam logic [3:0] reg_baud_port2 = 4'h8;
   localparam logic [3:0] reg_flow       = 4'hc;
   localparam logic [3:0] reg_rx_timeout = 4'h0; // second bank, see addr bit 4
   localparam logic [4:0] adr_baud_all   = 5'h00;
   localparam logic [4:0] adr_baud_port1 = 5'h04;
   localparam logic [4:0] adr_baud_port2 = 5'h08;
   localparam logic [4:0] adr_flow       = 5'h0c;
   localparam logic [4:0] adr_timeout    = 5'h10;
   localparam logic [4:0] adr_status     = 5'h14;

   // reset values
   localparam logic [16:0] baud_default    = 17'h0e100; // 57600
   localparam logic [13:0] timeout_default = 14'h03e8;  // 1000 ms
   localparam logic [13:0] timeout_min     = 14'h0005;  // 5 ms
   localparam logic [13:0] timeout_max     = 14'h2710;  // 10000 ms
   localparam logic        flow_default    = 1'b0;

   // field layout of baud_all: two rates packed, port2 in upper half
   localparam int baud_w      = 17;
   localparam int both_flag   = 31;   // set: low 15 bits x8 / upper split
   localparam int timeout_w   = 14;

   // timing: one millisecond tick from 100 MHz
   localparam int clk_hz      = 100_000_000;
   localparam int tick_ms_den = 1000;
   localparam int cycles_per_ms = clk_hz / tick_ms_den;

   // port rates travel together
   typedef struct packed {
      logic [16:0] port1;
      logic [16:0] port2;
   } baud_pair_t;

   typedef enum logic [1:0] {
      rx_idle    = 2'b00,
      rx_collect = 2'b01,
      rx_discard = 2'b11
   } rx_state_t;

endpackage

/* File: core/ms_tick.sv */
`timescale 1ns/100ps
`default_nettype none
module ms_tick #(
   parameter int cycles = serial_link_pkg::cycles_per_ms
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // restart and tick
   input  wire logic restart,
   output logic      tick
);
   // elaboration-time refusal of a divider that cannot count
   if (cycles < 1) begin
      $error("ms_tick needs at least one cycle");
   end

   logic [31:0] count;
   logic [31:0] next_count;

   // divider restarts with each character so a whole ms is counted
   always_comb begin
      next_count = count + 32'h1;
      if (restart || count == 32'(cycles - 1)) begin
         next_count = 32'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count <= 32'h0;
      end else begin
         count <= next_count;
      end
   end

   assign tick = !restart && (count == 32'(cycles - 1));
endmodule
`default_nettype wire

/* File: core/serial_link_settings.sv */
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module serial_link_settings #(
   parameter int cycles_per_ms = serial_link_pkg::cycles_per_ms
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // classic wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // receiver side, same clock
   input  wire logic        rx_char_valid,
   // serial pins and receive fifo full flag
   input  wire logic        cts_pin_b,
   output logic             rts_pin_b,
   input  wire logic        rx_fifo_full,
   // applied settings
   output logic [16:0]      baud_port1,
   output logic [16:0]      baud_port2,
   output logic             flow_enable,
   output logic             discard_partial,
   output logic             tx_allowed
);
   // elaboration-time refusal of a tick rate the divider cannot serve
   if (cycles_per_ms < 1) begin
      $error("cycles_per_ms must be at least one");
   end

   serial_link_pkg::baud_pair_t baud;
   serial_link_pkg::baud_pair_t next_baud;
   logic                        flow;
   logic                        next_flow;
   logic [13:0]                 timeout;
   logic [13:0]                 next_timeout;
   logic [13:0]                 ms_count;
   logic [13:0]                 next_ms_count;
   serial_link_pkg::rx_state_t  state;
   serial_link_pkg::rx_state_t  next_state;
   logic                        discard_seen;
   logic                        next_discard_seen;
   logic                        ack;
   logic                        next_ack;
   logic                        err;
   logic                        next_err;
   logic [31:0]                 rdata;
   logic [31:0]                 next_rdata;
   logic                        cts_meta;
   logic                        cts_sync_b;
   logic                        tick;
   logic                        req;
   logic                        full_word;

   // cts pin crosses in from outside: two flops before use
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cts_meta   <= 1'b1;
         cts_sync_b <= 1'b1;
      end else begin
         cts_meta   <= cts_pin_b;
         cts_sync_b <= cts_meta;
      end
   end

   ms_tick #(
      .cycles(cycles_per_ms)
   ) u_tick (
      .clk_sys(clk_sys),
      .rst_b  (rst_b),
      .restart(rx_char_valid),
      .tick   (tick)
   );

   // new request only while no answer is pending, so ack drops next cycle
   assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign full_word = (wb_sel_i == 4'hf);

   // register writes and reads; partial-lane writes are ignored, except at flow, which needs only lane 0
   always_comb begin
      next_baud    = baud;
      next_flow    = flow;
      next_timeout = timeout;
      next_ack     = 1'b0;
      next_err     = 1'b0;
      next_rdata   = 32'h0;
      if (req) begin
         next_ack = 1'b1;
         case (wb_adr_i)
            serial_link_pkg::adr_baud_all: begin
               if (wb_we_i && full_word) begin
                  if (wb_dat_i[serial_link_pkg::both_flag]) begin
                     // packed pair in units of 8 baud; top unit bit of each half overflows 17 bits, dropped
                     next_baud.port1 = {wb_dat_i[13:0], 3'b000};
                     next_baud.port2 = {wb_dat_i[28:15], 3'b000};
                  end else begin
                     next_baud.port1 = wb_dat_i[16:0];
                     next_baud.port2 = wb_dat_i[16:0];
                  end
               end
               next_rdata = {15'h0, baud.port1};
            end
            serial_link_pkg::adr_baud_port1: begin
               if (wb_we_i && full_word) begin
                  next_baud.port1 = wb_dat_i[16:0];
               end
               next_rdata = {15'h0, baud.port1};
            end
            serial_link_pkg::adr_baud_port2: begin
               if (wb_we_i && full_word) begin
                  next_baud.port2 = wb_dat_i[16:0];
               end
               next_rdata = {15'h0, baud.port2};
            end
            serial_link_pkg::adr_flow: begin
               if (wb_we_i && wb_sel_i[0]) begin
                  next_flow = wb_dat_i[0];
               end
               next_rdata = {31'h0, flow};
            end
            serial_link_pkg::adr_timeout: begin
               // out-of-range values are refused, old value kept
               if (wb_we_i && full_word && wb_dat_i[31:14] == 18'h0 &&
                   wb_dat_i[13:0] >= serial_link_pkg::timeout_min &&
                   wb_dat_i[13:0] <= serial_link_pkg::timeout_max) begin
                  next_timeout = wb_dat_i[13:0];
               end
               next_rdata = {18'h0, timeout};
            end
            serial_link_pkg::adr_status: begin
               next_rdata = {29'h0, discard_seen, state == serial_link_pkg::rx_collect, !cts_sync_b};
            end
            default: begin
               next_ack = 1'b0;
               next_err = 1'b1;
            end
         endcase
      end
   end

   // receive timeout machine: timer restarts per character
   always_comb begin
      next_state        = state;
      next_ms_count     = ms_count;
      next_discard_seen = discard_seen;
      case (state)
         serial_link_pkg::rx_idle: begin
            if (rx_char_valid) begin
               next_state    = serial_link_pkg::rx_collect;
               next_ms_count = 14'h0;
            end
         end
         serial_link_pkg::rx_collect: begin
            if (rx_char_valid) begin
               next_ms_count = 14'h0;
            end else if (tick) begin
               next_ms_count = ms_count + 14'h1;
               if (ms_count + 14'h1 >= timeout) begin
                  next_state = serial_link_pkg::rx_discard;
               end
            end
         end
         serial_link_pkg::rx_discard: begin
            next_state        = serial_link_pkg::rx_idle;
            next_discard_seen = 1'b1;
            // a char landing in the discard cycle opens a fresh command
            if (rx_char_valid) begin
               next_state    = serial_link_pkg::rx_collect;
               next_ms_count = 14'h0;
            end
         end
         default: begin
            next_state = serial_link_pkg::rx_idle;
         end
      endcase
      // status read clears sticky flag; a new discard in same cycle wins
      if (req && !wb_we_i && wb_adr_i == serial_link_pkg::adr_status &&
          state != serial_link_pkg::rx_discard) begin
         next_discard_seen = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         baud.port1   <= serial_link_pkg::baud_default;
         baud.port2   <= serial_link_pkg::baud_default;
         flow         <= serial_link_pkg::flow_default;
         timeout      <= serial_link_pkg::timeout_default;
         ack          <= 1'b0;
         err          <= 1'b0;
         rdata        <= 32'h0;
         state        <= serial_link_pkg::rx_idle;
         ms_count     <= 14'h0;
         discard_seen <= 1'b0;
      end else begin
         baud         <= next_baud;
         flow         <= next_flow;
         timeout      <= next_timeout;
         ack          <= next_ack;
         err          <= next_err;
         rdata        <= next_rdata;
         state        <= next_state;
         ms_count     <= next_ms_count;
         discard_seen <= next_discard_seen;
      end
   end

   assign wb_ack_o        = ack;
   assign wb_err_o        = err;
   assign wb_dat_o        = rdata;
   assign baud_port1      = baud.port1;
   assign baud_port2      = baud.port2;
   assign flow_enable     = flow;
   assign discard_partial = (state == serial_link_pkg::rx_discard);
   // handshake only when enabled; host must match the mode
   assign rts_pin_b       = flow ? rx_fifo_full : 1'b0;
   assign tx_allowed      = flow ? !cts_sync_b : 1'b1;
endmodule
`default_nettype wire

/* File: bench/host_port_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // bench controls
   input  wire logic send_req,
   input  wire logic host_ready,
   // device pins and mode
   input  wire logic rts_pin_b,
   input  wire logic flow_enable,
   output logic      rx_char_valid,
   output logic      cts_pin_b
);
   // host opens its port in the device's mode, so it holds off while rts is high
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) rx_char_valid <= 1'b0;
      else rx_char_valid <= send_req && (!flow_enable || !rts_pin_b);
   end
   assign cts_pin_b = !host_ready; // low means host can take data
endmodule
`default_nettype wire

/* File: bench/serial_link_settings_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_link_settings_asserts #(
   parameter int cycles_per_ms = 10
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   input  wire logic        wb_err_o,
   // link and settings
   input  wire logic        rx_char_valid,
   input  wire logic        rx_fifo_full,
   input  wire logic        rts_pin_b,
   input  wire logic [16:0] baud_port1,
   input  wire logic [16:0] baud_port2,
   input  wire logic        flow_enable,
   input  wire logic        discard_partial
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic take;
   // a request is taken only while no answer is showing
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   a_bus_answer: assert property (take |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o))
      else $error("bus answer missing or held");
   a_both_ports: assert property (
      take && wb_we_i && wb_adr_i == 5'h00 && wb_sel_i == 4'hf && !wb_dat_i[31] |=>
      baud_port1 == $past(wb_dat_i[16:0]) && baud_port2 == $past(wb_dat_i[16:0])) else $error("rate not on both");
   a_port1_only: assert property (
      take && wb_we_i && wb_adr_i == 5'h04 && wb_sel_i == 4'hf |=>
      baud_port1 == $past(wb_dat_i[16:0]) && $stable(baud_port2)) else $error("port write leaked");
   a_flow_write: assert property (
      take && wb_we_i && wb_adr_i == 5'h0c && wb_sel_i[0] |=> flow_enable == $past(wb_dat_i[0]))
      else $error("flow bit not written");
   a_flow_read: assert property (
      take && !wb_we_i && wb_adr_i == 5'h0c |=> wb_dat_o == {31'h0, flow_enable}) else $error("flow read wrong");
   a_rts_level: assert property (rts_pin_b == (flow_enable && rx_fifo_full))
      else $error("rts level wrong");
   a_discard_once: assert property (discard_partial |=> !discard_partial)
      else $error("discard held");
   a_char_restart: assert property (rx_char_valid |=> !discard_partial [*3])
      else $error("discard right after char");
   // main scenarios reached
   cover property (discard_partial);
   cover property (wb_err_o);
   cover property (flow_enable && rx_fifo_full);
endmodule
bind serial_link_settings serial_link_settings_asserts #(.cycles_per_ms(cycles_per_ms)) chk_u (
   .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .rx_char_valid(rx_char_valid), .rx_fifo_full(rx_fifo_full), .rts_pin_b(rts_pin_b),
   .baud_port1(baud_port1), .baud_port2(baud_port2), .flow_enable(flow_enable), .discard_partial(discard_partial));
`default_nettype wire

/* File: bench/serial_link_settings_test.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_link_settings_test;
   typedef struct packed {
      logic        we;
      logic [4:0]  a;
      logic [31:0] d;
      logic [31:0] x;
   } row_t;
   logic        clk_sys, rst_b, req, we, ack, err, send_req, host_ready, fifo_full;
   logic        flow, disc, rts_b, cts_b, rxv, txa, er;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dw, q, rd;
   logic [16:0] b1, b2;
   int          n_errors, comparisons, n;
   // reads carry the value they should return
   row_t rows [22] = '{
      '{1'b0, 5'h04, 32'h0, 32'he100}, '{1'b0, 5'h10, 32'h0, 32'h3e8}, '{1'b0, 5'h0c, 32'h0, 32'h0},
      '{1'b1, 5'h00, 32'h1c200, 32'h0}, '{1'b0, 5'h04, 32'h0, 32'h1c200}, '{1'b0, 5'h08, 32'h0, 32'h1c200},
      '{1'b1, 5'h08, 32'he100, 32'h0}, '{1'b0, 5'h04, 32'h0, 32'h1c200},
      '{1'b1, 5'h04, 32'h4b00, 32'h0}, '{1'b0, 5'h04, 32'h0, 32'h4b00}, '{1'b0, 5'h08, 32'h0, 32'he100},
      '{1'b1, 5'h00, 32'h9c201c20, 32'h0}, '{1'b0, 5'h04, 32'h0, 32'he100}, '{1'b0, 5'h08, 32'h0, 32'h1c200},
      '{1'b1, 5'h10, 32'h2710, 32'h0}, '{1'b0, 5'h10, 32'h0, 32'h2710}, '{1'b1, 5'h10, 32'h2711, 32'h0},
      '{1'b0, 5'h10, 32'h0, 32'h2710}, '{1'b1, 5'h10, 32'h5, 32'h0}, '{1'b0, 5'h10, 32'h0, 32'h5},
      '{1'b1, 5'h0c, 32'h1, 32'h0}, '{1'b0, 5'h0c, 32'h0, 32'h1}};
   serial_link_settings #(.cycles_per_ms(10)) dut_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err), .rx_char_valid(rxv),
      .cts_pin_b(cts_b), .rts_pin_b(rts_b), .rx_fifo_full(fifo_full), .baud_port1(b1), .baud_port2(b2),
      .flow_enable(flow), .discard_partial(disc), .tx_allowed(txa));
   host_port_model host_u (
      .clk_sys(clk_sys), .rst_b(rst_b), .send_req(send_req), .host_ready(host_ready),
      .rts_pin_b(rts_b), .flow_enable(flow), .rx_char_valid(rxv), .cts_pin_b(cts_b));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one classic cycle, held until ack or err is seen at an edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      req <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      sel <= 4'hf;
      for (k = 0; k < 20 && ack !== 1'b1 && err !== 1'b1; k++) @(posedge clk_sys);
      if (k == 20) begin
         n_errors++;
         wrap_up;
      end
      rd = q;
      er = err;
      req <= 1'b0;
      @(posedge clk_sys);
   endtask
   // short char pulse request to the host model
   task automatic send_char;
      send_req <= 1'b1;
      @(posedge clk_sys);
      send_req <= 1'b0;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      {rst_b, req, we, adr, dw, sel, send_req, host_ready, fifo_full} = '0;
      n_errors = 0;
      comparisons = 0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      foreach (rows[i]) begin
         bus(rows[i].we, rows[i].a, rows[i].d);
         if (!rows[i].we) chk(rd, rows[i].x);
      end
      // flow on: rts follows the full flag, cts gates sending
      fifo_full <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(rts_b, 1'b1);
      chk(txa, 1'b0);
      // host ready: synced cts lets sending through after two flops
      host_ready <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(txa, 1'b1);
      fifo_full <= 1'b0;
      send_char();
      repeat (30) @(posedge clk_sys);
      send_char();
      // second char must restart the 5 ms count
      for (n = 0; n < 200 && disc !== 1'b1; n++) @(posedge clk_sys);
      chk(n >= 50 && n <= 56, 1'b1);
      // sticky discard flag shows once, with cts asserted, then clears
      bus(1'b0, 5'h14, 32'h0);
      chk(rd, 32'h5);
      bus(1'b0, 5'h14, 32'h0);
      chk(rd, 32'h1);
      bus(1'b0, 5'h18, 32'h0);
      chk(er, 1'b1);
      // reset in mid-run restores defaults
      rst_b <= 1'b0;
      @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      bus(1'b0, 5'h0c, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 5'h10, 32'h0);
      chk(rd, 32'h3e8);
      chk(b2, 32'he100);
      wrap_up;
   end
endmodule
`default_nettype wire
